// [rtl/isrc_regs.svh]
`ifndef ISRC_REGS_SVH
`define ISRC_REGS_SVH

// Register byte offsets
`define ISRC_OFF_PSC0      12'h000
`define ISRC_OFF_PSC1      12'h004
`define ISRC_OFF_TBC0      12'h008
`define ISRC_OFF_TBC1      12'h00C
`define ISRC_OFF_CTRL      12'h010
`define ISRC_OFF_FLAG      12'h014
`define ISRC_OFF_MFSRC     12'h018

// Prescaler source select and time-base control fields
`define ISRC_PSC_SEL_MSB   1
`define ISRC_PSC_SEL_LSB   0
`define ISRC_TBC_ON_BIT    7
`define ISRC_TBC_CODE_MSB  2
`define ISRC_TBC_CODE_LSB  0

// Control register fields
`define ISRC_CTRL_GIE      0
`define ISRC_CTRL_CMP_EN   1
`define ISRC_CTRL_ADC_EN   2
`define ISRC_CTRL_TB_EN_LSB 3
`define ISRC_CTRL_SER_EN   5
`define ISRC_CTRL_MF_EN_LSB 6

// Flag register fields
`define ISRC_FLAG_CMP      0
`define ISRC_FLAG_ADC      1
`define ISRC_FLAG_TB_LSB   2
`define ISRC_FLAG_SER      4
`define ISRC_FLAG_MF_LSB   5

// Grouped source register: flags in 7..0, enables in 15..8
`define ISRC_MFS_EN_LSB    8
`define ISRC_MF0_MASK      8'h09
`define ISRC_MF1_MASK      8'h36
`define ISRC_MF2_MASK      8'hC0

// Reset values and timing counts
`define ISRC_RST_REG       8'h00
`define ISRC_DIV4_LAST     2'h3
`define ISRC_CNT_FULL      15'h7FFF
`define ISRC_CODE_MAX      3'h7

`endif

// [rtl/isrc_pkg.sv]
package isrc_pkg;

    typedef enum logic [2:0]
    {
        ISRC_VEC_CMP  = 3'b000,
        ISRC_VEC_MF0  = 3'b001,
        ISRC_VEC_MF1  = 3'b010,
        ISRC_VEC_MF2  = 3'b011,
        ISRC_VEC_ADC  = 3'b100,
        ISRC_VEC_TB0  = 3'b101,
        ISRC_VEC_SER  = 3'b110,
        ISRC_VEC_TB1  = 3'b111
    } isrc_vec_t;

    typedef struct packed
    {
        logic [1:0]        cmp_sync;
        logic              cmp_prev;
        logic [1:0]        sub_sync;
        logic              sub_prev;
        logic [1:0]        div4;
        logic [1:0][1:0]   psc_sel;
        logic [1:0]        tb_on;
        logic [1:0][2:0]   tb_code;
        logic [1:0][14:0]  tb_cnt;
        logic              gie;
        logic              cmp_en;
        logic              adc_en;
        logic [1:0]        tb_en;
        logic              ser_en;
        logic [2:0]        mf_en;
        logic              cmp_f;
        logic              adc_f;
        logic [1:0]        tb_f;
        logic              ser_f;
        logic [2:0]        mf_f;
        logic [7:0]        src_f;
        logic [7:0]        src_en;
        logic              irq_req;
        isrc_vec_t         vec;
        logic              wake;
        logic [31:0]       rdata;
        logic              slverr;
        logic              acc_ok;
    } isrc_state_t;

endpackage

// [rtl/isrc_top.sv]
// Operation
// - Comparator output toggle sets its flag
// - Comparator call needs global, own enable, room
// - Comparator service clears flag and global enable
// - Three grouped channels fed by timer, voltage, memory
// - Any member flag rising sets group flag
// - Group service clears group flag, global; keeps member flags
// - Conversion end sets converter flag
// - Converter call gated; service clears flag, global
// - Each tick divider overflow sets its flag
// - Tick call needs global, unit enable, room
// - Tick service clears its flag, global enable
// - Prescaler source: system, system/4, sub clock
// - Control bit 7 switches tick unit on
// - Period code gives 2^(8+code) prescaler periods
// - Unimplemented select and control bits read zero
// - Timer compare A and P flags, own enables
// - Timer call needs global, source, group enable
// - Serial byte, address match, timeout set flag
// - Serial call gated; service clears flag, global
// - Flags set even while enable is low
// - Full stack blocks every request
// - Any flag rising produces a wake-up pulse
`timescale 1ns/100ps
`include "isrc_regs.svh"

module isrc_top
(
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cmp_out_i,
    input  wire logic        sub_clk_i,
    input  wire logic        adc_done_i,
    input  wire logic [2:0]  tm_a_match_i,
    input  wire logic [2:0]  tm_p_match_i,
    input  wire logic        lvd_detect_i,
    input  wire logic        ee_done_i,
    input  wire logic        serial_byte_i,
    input  wire logic        serial_addr_match_i,
    input  wire logic        serial_timeout_i,
    input  wire logic        stack_full_i,
    input  wire logic        irq_ack_i,
    input  wire logic        reti_i,
    output logic             irq_req_o,
    output logic [2:0]       irq_vector_o,
    output logic             wake_o
);

    isrc_pkg::isrc_state_t s;
    isrc_pkg::isrc_state_t n;

    logic [1:0] psc_tick;
    logic [1:0] tb_ovf;
    logic       sub_rise;
    logic       wr_done;
    logic [7:0] elig;
    logic [7:0] src_rise;
    logic [7:0] src_act;

    // Mask of counter bits whose all-ones state ends one period
    function automatic logic [14:0] period_mask(input logic [2:0] code);
        period_mask = `ISRC_CNT_FULL >> (`ISRC_CODE_MAX - code);
    endfunction

    // Prescaler clock tick for one source select code
    function automatic logic psc_pulse(input logic [1:0] sel, input logic [1:0] div4, input logic sub_edge);
        logic p;
        p = 1'b0;
        case (sel)
            2'b00:   p = 1'b1;
            2'b01:   p = (div4 == `ISRC_DIV4_LAST);
            default: p = sub_edge;
        endcase
        psc_pulse = p;
    endfunction

    function automatic logic [31:0] read_mux(input logic [11:0] a, input isrc_pkg::isrc_state_t r);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `ISRC_OFF_PSC0:  d = {30'h0, r.psc_sel[0]};
            `ISRC_OFF_PSC1:  d = {30'h0, r.psc_sel[1]};
            `ISRC_OFF_TBC0:  d = {24'h0, r.tb_on[0], 4'h0, r.tb_code[0]};
            `ISRC_OFF_TBC1:  d = {24'h0, r.tb_on[1], 4'h0, r.tb_code[1]};
            `ISRC_OFF_CTRL:  d = {23'h0, r.mf_en, r.ser_en, r.tb_en, r.adc_en, r.cmp_en, r.gie};
            `ISRC_OFF_FLAG:  d = {24'h0, r.mf_f, r.ser_f, r.tb_f, r.adc_f, r.cmp_f};
            `ISRC_OFF_MFSRC: d = {16'h0, r.src_en, r.src_f};
            default:         d = 32'h0000_0000;
        endcase
        read_mux = d;
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `ISRC_OFF_PSC0) || (a == `ISRC_OFF_PSC1) || (a == `ISRC_OFF_TBC0)
                   || (a == `ISRC_OFF_TBC1) || (a == `ISRC_OFF_CTRL) || (a == `ISRC_OFF_FLAG)
                   || (a == `ISRC_OFF_MFSRC);
    endfunction

    assign sub_rise = s.sub_sync[1] & ~s.sub_prev;
    assign wr_done  = psel_i & penable_i & s.acc_ok & pwrite_i & ~s.slverr;

    always_comb
    begin
        n = s;
        // Two-stage synchronisers for the comparator level and the sub clock
        n.cmp_sync = {s.cmp_sync[0], cmp_out_i};
        n.cmp_prev = s.cmp_sync[1];
        n.sub_sync = {s.sub_sync[0], sub_clk_i};
        n.sub_prev = s.sub_sync[1];
        n.div4     = s.div4 + 2'h1;
        n.wake     = 1'b0;

        for (int u = 0; u < 2; u++)
        begin
            psc_tick[u] = psc_pulse(s.psc_sel[u], s.div4, sub_rise);
            tb_ovf[u]   = s.tb_on[u] & psc_tick[u]
                        & ((s.tb_cnt[u] & period_mask(s.tb_code[u])) == period_mask(s.tb_code[u]));
            if (!s.tb_on[u])
            begin
                n.tb_cnt[u] = 15'h0000;
            end
            else if (tb_ovf[u])
            begin
                n.tb_cnt[u] = 15'h0000;
            end
            else if (psc_tick[u])
            begin
                n.tb_cnt[u] = s.tb_cnt[u] + 15'h0001;
            end
        end

        // Bus: setup captures read data, access completes the transfer
        if (psel_i && !penable_i)
        begin
            n.acc_ok = 1'b1;
            n.rdata  = read_mux(paddr_i, s);
            n.slverr = ~addr_mapped(paddr_i);
        end
        else if (psel_i && penable_i && s.acc_ok)
        begin
            n.acc_ok = 1'b0;
        end

        if (wr_done)
        begin
            case (paddr_i)
                `ISRC_OFF_PSC0:  n.psc_sel[0] = pwdata_i[`ISRC_PSC_SEL_MSB:`ISRC_PSC_SEL_LSB];
                `ISRC_OFF_PSC1:  n.psc_sel[1] = pwdata_i[`ISRC_PSC_SEL_MSB:`ISRC_PSC_SEL_LSB];
                `ISRC_OFF_TBC0:
                begin
                    n.tb_on[0]   = pwdata_i[`ISRC_TBC_ON_BIT];
                    n.tb_code[0] = pwdata_i[`ISRC_TBC_CODE_MSB:`ISRC_TBC_CODE_LSB];
                end
                `ISRC_OFF_TBC1:
                begin
                    n.tb_on[1]   = pwdata_i[`ISRC_TBC_ON_BIT];
                    n.tb_code[1] = pwdata_i[`ISRC_TBC_CODE_MSB:`ISRC_TBC_CODE_LSB];
                end
                `ISRC_OFF_CTRL:
                begin
                    n.gie    = pwdata_i[`ISRC_CTRL_GIE];
                    n.cmp_en = pwdata_i[`ISRC_CTRL_CMP_EN];
                    n.adc_en = pwdata_i[`ISRC_CTRL_ADC_EN];
                    n.tb_en  = pwdata_i[`ISRC_CTRL_TB_EN_LSB +: 2];
                    n.ser_en = pwdata_i[`ISRC_CTRL_SER_EN];
                    n.mf_en  = pwdata_i[`ISRC_CTRL_MF_EN_LSB +: 3];
                end
                `ISRC_OFF_FLAG:
                begin
                    n.cmp_f = pwdata_i[`ISRC_FLAG_CMP];
                    n.adc_f = pwdata_i[`ISRC_FLAG_ADC];
                    n.tb_f  = pwdata_i[`ISRC_FLAG_TB_LSB +: 2];
                    n.ser_f = pwdata_i[`ISRC_FLAG_SER];
                    n.mf_f  = pwdata_i[`ISRC_FLAG_MF_LSB +: 3];
                end
                `ISRC_OFF_MFSRC:
                begin
                    n.src_f  = pwdata_i[7:0];
                    n.src_en = pwdata_i[`ISRC_MFS_EN_LSB +: 8];
                end
                default:
                begin
                end
            endcase
        end

        // Return from service re-opens the global enable
        if (reti_i)
        begin
            n.gie = 1'b1;
        end

        // Acknowledge clears the granted flag and the global enable
        if (irq_ack_i && s.irq_req)
        begin
            n.gie = 1'b0;
            case (s.vec)
                isrc_pkg::ISRC_VEC_CMP: n.cmp_f    = 1'b0;
                isrc_pkg::ISRC_VEC_MF0: n.mf_f[0]  = 1'b0;
                isrc_pkg::ISRC_VEC_MF1: n.mf_f[1]  = 1'b0;
                isrc_pkg::ISRC_VEC_MF2: n.mf_f[2]  = 1'b0;
                isrc_pkg::ISRC_VEC_ADC: n.adc_f    = 1'b0;
                isrc_pkg::ISRC_VEC_TB0: n.tb_f[0]  = 1'b0;
                isrc_pkg::ISRC_VEC_SER: n.ser_f    = 1'b0;
                isrc_pkg::ISRC_VEC_TB1: n.tb_f[1]  = 1'b0;
                default:
                begin
                end
            endcase
        end

        // Hardware sets come last so an event beats a same-cycle clear
        if (s.cmp_sync[1] != s.cmp_prev)
        begin
            n.cmp_f = 1'b1;
        end
        if (adc_done_i)
        begin
            n.adc_f = 1'b1;
        end
        for (int u = 0; u < 2; u++)
        begin
            if (tb_ovf[u])
            begin
                n.tb_f[u] = 1'b1;
            end
        end
        if (serial_byte_i || serial_addr_match_i || serial_timeout_i)
        begin
            n.ser_f = 1'b1;
        end
        n.src_f = n.src_f | {ee_done_i, lvd_detect_i, tm_p_match_i, tm_a_match_i};

        // Group flag follows any member flag going high
        src_rise = n.src_f & ~s.src_f;
        if (|(src_rise & `ISRC_MF0_MASK))
        begin
            n.mf_f[0] = 1'b1;
        end
        if (|(src_rise & `ISRC_MF1_MASK))
        begin
            n.mf_f[1] = 1'b1;
        end
        if (|(src_rise & `ISRC_MF2_MASK))
        begin
            n.mf_f[2] = 1'b1;
        end

        // Arbitration on the updated flags so a serviced request drops at once
        src_act = n.src_f & n.src_en;
        elig[0] = n.cmp_f & n.cmp_en;
        elig[1] = n.mf_f[0] & n.mf_en[0] & |(src_act & `ISRC_MF0_MASK);
        elig[2] = n.mf_f[1] & n.mf_en[1] & |(src_act & `ISRC_MF1_MASK);
        elig[3] = n.mf_f[2] & n.mf_en[2] & |(src_act & `ISRC_MF2_MASK);
        elig[4] = n.adc_f & n.adc_en;
        elig[5] = n.tb_f[0] & n.tb_en[0];
        elig[6] = n.ser_f & n.ser_en;
        elig[7] = n.tb_f[1] & n.tb_en[1];
        n.irq_req = n.gie & ~stack_full_i & (|elig);
        n.vec     = s.vec;
        for (int i = 7; i >= 0; i--)
        begin
            if (elig[i])
            begin
                n.vec = isrc_pkg::isrc_vec_t'(i[2:0]);
            end
        end

        // Wake-up on any flag rising, enables ignored
        n.wake = (n.cmp_f & ~s.cmp_f) | (n.adc_f & ~s.adc_f) | (n.ser_f & ~s.ser_f)
               | |(n.tb_f & ~s.tb_f) | |(n.mf_f & ~s.mf_f) | |src_rise;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            s <= '0;
        end
        else if (ce_i)
        begin
            s <= n;
        end
    end

    assign prdata_o     = s.rdata;
    assign pslverr_o    = s.slverr & s.acc_ok & psel_i & penable_i;
    assign pready_o     = s.acc_ok & ce_i;
    assign irq_req_o    = s.irq_req;
    assign irq_vector_o = s.vec;
    assign wake_o       = s.wake;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence serviced_s;
        ce_i && irq_ack_i && irq_req_o;
    endsequence

    sequence mf_serviced_s;
        serviced_s ##0 (irq_vector_o inside {3'b001, 3'b010, 3'b011}) ##0 !wr_done;
    endsequence

    cmp_toggle_a: assert property (ce_i && (s.cmp_sync[1] != s.cmp_prev) |=> s.cmp_f)
        else $error("comparator toggle did not set flag");

    cmp_service_a: assert property (serviced_s ##0 irq_vector_o == 3'b000 ##0 !reti_i
                                    |=> !s.gie && (s.cmp_f == $past(s.cmp_sync[1] != s.cmp_prev)))
        else $error("comparator service left flag or enable set");

    group_keep_a: assert property (mf_serviced_s |=> (($past(s.src_f) & ~s.src_f) == 8'h00))
        else $error("group service cleared a member flag");

    tick_flag_a: assert property (ce_i && tb_ovf[0] |=> s.tb_f[0] ##0 s.tb_cnt[0] == 15'h0000)
        else $error("tick overflow lost");

    req_gate_a: assert property (irq_req_o |-> s.gie && $past(!stack_full_i || !ce_i))
        else $error("request without global enable or with full stack");

    stack_block_a: assert property (ce_i && stack_full_i |=> !irq_req_o)
        else $error("request raised while stack full");

    flag_noen_a: assert property (ce_i && adc_done_i && !s.adc_en |=> s.adc_f && !(s.vec == 3'b100 && irq_req_o))
        else $error("disabled converter flag missing or vectored");

    wake_rise_a: assert property (ce_i && adc_done_i && !s.adc_f |=> wake_o ##1 (!wake_o || !ce_i || $past(ce_i)))
        else $error("flag rise gave no wake pulse");

    prio_low_a: assert property (irq_req_o && s.cmp_f && s.cmp_en |-> irq_vector_o == 3'b000)
        else $error("comparator lost priority");

    psc_zero_a: assert property (ce_i && psel_i && !penable_i && paddr_i == `ISRC_OFF_PSC0
                                 |=> prdata_o[31:2] == 30'h0)
        else $error("unimplemented select bits not zero");

    sequence tick1_serviced_s;
        serviced_s ##0 irq_vector_o == 3'b111;
    endsequence

    group_set_a: assert property (ce_i && |(src_rise & `ISRC_MF0_MASK) |=> s.mf_f[0])
        else $error("member flag rise did not set its group flag");

    adc_service_a: assert property (serviced_s ##0 irq_vector_o == 3'b100
                                    |=> !s.gie && (s.adc_f == $past(adc_done_i)))
        else $error("converter service left flag or enable set");

    ser_service_a: assert property (serviced_s ##0 irq_vector_o == 3'b110
                                    |=> !s.gie && (s.ser_f == $past(serial_byte_i || serial_addr_match_i
                                                                   || serial_timeout_i)))
        else $error("serial service left flag or enable set");

    tick_service_a: assert property (tick1_serviced_s
                                     |=> !s.gie && (s.tb_f[1] == $past(tb_ovf[1])))
        else $error("tick service left flag or enable set");

    tick_gate_a: assert property (irq_req_o && irq_vector_o == 3'b111
                                  |-> s.gie && s.tb_en[1] && s.tb_f[1])
        else $error("tick request without its enables");

    tick_off_a: assert property (ce_i && !s.tb_on[0] |=> s.tb_cnt[0] == 15'h0000)
        else $error("tick counter ran while unit off");

    tick1_flag_a: assert property (ce_i && tb_ovf[1] |=> s.tb_f[1])
        else $error("second tick overflow lost");

    ser_set_a: assert property (ce_i && (serial_byte_i || serial_addr_match_i
                                || serial_timeout_i) |=> s.ser_f)
        else $error("serial event did not set flag");

endmodule

// [verification/isrc_core_model.sv]
`timescale 1ns/100ps

module isrc_core_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    input  wire logic       irq_req_i,
    input  wire logic [2:0] irq_vector_i,
    input  wire logic [3:0] ack_delay_i,
    input  wire logic       reti_cmd_i,
    output logic            irq_ack_o,
    output logic            reti_o,
    output logic [2:0]      last_vec_o,
    output logic [7:0]      ack_count_o
);
    logic [3:0] wait_r;

    // Takes a pending vector after a chosen number of cycles, like a core finishing an instruction
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            wait_r      <= 4'h0;
            irq_ack_o   <= 1'b0;
            reti_o      <= 1'b0;
            last_vec_o  <= 3'h0;
            ack_count_o <= 8'h00;
        end
        else
        begin
            irq_ack_o <= 1'b0;
            reti_o    <= reti_cmd_i;
            if (!irq_req_i || irq_ack_o)
                wait_r <= 4'h0;
            else if (wait_r >= ack_delay_i)
            begin
                irq_ack_o   <= 1'b1;
                last_vec_o  <= irq_vector_i;
                ack_count_o <= ack_count_o + 8'h01;
            end
            else
                wait_r <= wait_r + 4'h1;
        end
    end
endmodule

// [verification/interrupt_sources_and_time_base_bench.sv]
`timescale 1ns/100ps
`include "isrc_regs.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
    $display("BAD %s expected %0h seen %0h", n, e, s); end end

module interrupt_sources_and_time_base_bench;
    logic        ref_clk_i;
    logic        srst_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmp_out;
    logic [11:0] ev;
    logic        stack_full;
    logic        irq_ack;
    logic        reti;
    logic        reti_cmd;
    logic [3:0]  ack_delay;
    logic        irq_req;
    logic [2:0]  irq_vec;
    logic        wake;
    logic        wake_s;
    logic        err_s;
    logic [2:0]  last_vec;
    logic [7:0]  ack_cnt;
    logic [1:0]  sub_div;
    int          num_errors;
    int          check_count;
    int          n_ack;

    isrc_top u_dut
    (
        .ref_clk_i           (ref_clk_i),
        .srst_i              (srst_i),
        .ce_i                (1'b1),
        .psel_i              (psel),
        .penable_i           (penable),
        .pwrite_i            (pwrite),
        .paddr_i             (paddr),
        .pwdata_i            (pwdata),
        .prdata_o            (prdata),
        .pready_o            (pready),
        .pslverr_o           (pslverr),
        .cmp_out_i           (cmp_out),
        .sub_clk_i           (sub_div[1]),
        .adc_done_i          (ev[11]),
        .tm_a_match_i        (ev[2:0]),
        .tm_p_match_i        (ev[5:3]),
        .lvd_detect_i        (ev[6]),
        .ee_done_i           (ev[7]),
        .serial_byte_i       (ev[8]),
        .serial_addr_match_i (ev[9]),
        .serial_timeout_i    (ev[10]),
        .stack_full_i        (stack_full),
        .irq_ack_i           (irq_ack),
        .reti_i              (reti),
        .irq_req_o           (irq_req),
        .irq_vector_o        (irq_vec),
        .wake_o              (wake)
    );

    isrc_core_model u_core
    (
        .ref_clk_i    (ref_clk_i),
        .srst_i       (srst_i),
        .irq_req_i    (irq_req),
        .irq_vector_i (irq_vec),
        .ack_delay_i  (ack_delay),
        .reti_cmd_i   (reti_cmd),
        .irq_ack_o    (irq_ack),
        .reti_o       (reti),
        .last_vec_o   (last_vec),
        .ack_count_o  (ack_cnt)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Free-running sub clock at a quarter of the system clock
    always @(posedge ref_clk_i)
    begin
        sub_div <= sub_div + 2'h1;
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        q     = prdata;
        err_s = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHK("register", e, q)
    endtask

    // One-cycle event; wake is sampled in the cycle after the flag-setting edge
    task automatic pulse(input logic [11:0] m);
        @(posedge ref_clk_i);
        ev <= m;
        @(posedge ref_clk_i);
        ev <= 12'h000;
        @(negedge ref_clk_i);
        wake_s = wake;
    endtask

    task automatic wait_ack(input logic [2:0] e);
        n_ack++;
        for (int k = 0; k < 40 && ack_cnt !== 8'(n_ack); k++)
            @(negedge ref_clk_i);
        `CHK("acks", 8'(n_ack), ack_cnt)
        `CHK("vector", e, last_vec)
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        summarize();
    end

    initial
    begin
        int cnt;
        int per;
        int grp;
        srst_i = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cmp_out, ev, stack_full, reti_cmd, ack_delay, sub_div} = '0;
        num_errors = 0;
        check_count = 0;
        n_ack = 0;
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        for (int u = 0; u < 4; u++)
        begin
            rchk(12'(4 * u), 32'h0);
            wr(12'(4 * u), 32'hFFFFFFFF);
            rchk(12'(4 * u), (u < 2) ? 32'h3 : 32'h87);
            wr(12'(4 * u), 32'h0);
        end
        rchk(12'h100, 32'h0);
        `CHK("unmapped error", 1'b1, err_s)
        for (int i = 0; i < 8; i++)
        begin
            grp = (i == 0 || i == 3) ? 0 : (i >= 6) ? 2 : 1;
            pulse(12'h001 << i);
            `CHK("wake", 1'b1, wake_s)
            rchk(`ISRC_OFF_MFSRC, 32'h1 << i);
            rchk(`ISRC_OFF_FLAG, 32'h1 << (5 + grp));
            wr(`ISRC_OFF_FLAG, 32'h0);
            wr(`ISRC_OFF_MFSRC, 32'h0);
        end
        // Grouped service keeps the member flag
        wr(`ISRC_OFF_MFSRC, 32'h0100);
        wr(`ISRC_OFF_CTRL, 32'h41);
        pulse(12'h001);
        wait_ack(3'h1);
        rchk(`ISRC_OFF_FLAG, 32'h0);
        rchk(`ISRC_OFF_MFSRC, 32'h0101);
        rchk(`ISRC_OFF_CTRL, 32'h40);
        wr(`ISRC_OFF_MFSRC, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            pulse(12'h100 << i);
            rchk(`ISRC_OFF_FLAG, 32'h10);
            wr(`ISRC_OFF_FLAG, 32'h0);
        end
        // Converter event with the global enable on and its own enable off
        wr(`ISRC_OFF_CTRL, 32'h1);
        pulse(12'h800);
        `CHK("wake", 1'b1, wake_s)
        repeat (8) @(negedge ref_clk_i);
        `CHK("request", 1'b0, irq_req)
        rchk(`ISRC_OFF_FLAG, 32'h2);
        @(posedge ref_clk_i);
        stack_full <= 1'b1;
        wr(`ISRC_OFF_CTRL, 32'h5);
        repeat (8) @(negedge ref_clk_i);
        `CHK("request", 1'b0, irq_req)
        @(posedge ref_clk_i);
        stack_full <= 1'b0;
        wait_ack(3'h4);
        rchk(`ISRC_OFF_FLAG, 32'h0);
        rchk(`ISRC_OFF_CTRL, 32'h4);
        // Two pending sources, slow core
        wr(`ISRC_OFF_CTRL, 32'h0);
        @(posedge ref_clk_i);
        cmp_out   <= 1'b1;
        ack_delay <= 4'h5;
        pulse(12'h100);
        repeat (4) @(negedge ref_clk_i);
        rchk(`ISRC_OFF_FLAG, 32'h11);
        wr(`ISRC_OFF_CTRL, 32'h23);
        wait_ack(3'h0);
        rchk(`ISRC_OFF_FLAG, 32'h10);
        rchk(`ISRC_OFF_CTRL, 32'h22);
        @(posedge ref_clk_i);
        reti_cmd <= 1'b1;
        @(posedge ref_clk_i);
        reti_cmd <= 1'b0;
        wait_ack(3'h6);
        rchk(`ISRC_OFF_FLAG, 32'h0);
        wr(`ISRC_OFF_CTRL, 32'h0);
        // Tick period: system clock, system clock over four (serviced), then sub clock with code one
        for (int u = 0; u < 3; u++)
        begin
            per = (u == 0) ? 256 : (u == 1) ? 1024 : 2048;
            if (u == 1)
                wr(`ISRC_OFF_CTRL, 32'h11);
            wr(`ISRC_OFF_PSC0 + 12'(4 * (u % 2)), 32'(u));
            wr(`ISRC_OFF_TBC0 + 12'(4 * (u % 2)), (u == 2) ? 32'h81 : 32'h80);
            cnt = 0;
            while (wake !== 1'b1 && cnt < 3000)
            begin
                @(negedge ref_clk_i);
                cnt++;
            end
            `CHK("period fits", 1'b1, cnt >= per - 6 && cnt <= per + 8)
            wr(`ISRC_OFF_TBC0 + 12'(4 * (u % 2)), 32'h0);
            if (u == 1)
                wait_ack(3'h7);
            rchk(`ISRC_OFF_FLAG, (u == 1) ? 32'h0 : 32'h4);
            wr(`ISRC_OFF_FLAG, 32'h0);
        end
        summarize();
    end
endmodule
